/* File: hdl/acl_pkg.sv */
/*
  constants for the add-with-carry and logic unit: opcode prefixes,
  field positions, addressing modes, status bit positions, register
  port map and reset values.
  assumes: included by every design file of the unit via acl_pkg::*.
*/
package acl_pkg;

  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int unsigned XLEN    = 16;  // datapath width
  localparam int unsigned NREG    = 16;  // working registers
  localparam int unsigned IW      = 24;  // instruction word
  localparam int unsigned RIDX_W  = 4;   // register number field
  localparam int unsigned MEM_AW  = 12;  // data memory word index
  localparam int unsigned BUS_AW  = 14;  // register port address
  localparam int unsigned WIDE_LITERAL_W = 10;  // wide literal field
  localparam int unsigned SHORT_LITERAL_W  = 5;   // short literal field
  localparam int unsigned FADR_W  = 13;  // file register address

  // -----------------------------------------------------------------
  // opcode prefixes and markers
  // -----------------------------------------------------------------
  localparam logic [7:0] OPC_LIT_ADD_WITH_CARRY  = 8'hb0;  // literal form
  localparam logic [4:0] OPC_REG_ADD_WITH_CARRY  = 5'h09;  // short / register form
  localparam logic [7:0] OPC_FILE_AND  = 8'hb6;  // file register AND
  localparam logic       LIT_MARK      = 1'h1;   // bit after literal prefix
  localparam logic       FAND_MARK     = 1'h0;   // bit after AND prefix
  localparam logic [1:0] SHORT_MARK    = 2'h3;   // ones marking short literal

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int unsigned F_OPC8   = 16;  // lsb of 8-bit prefix
  localparam int unsigned F_OPC5   = 19;  // lsb of 5-bit prefix
  localparam int unsigned F_MARK   = 15;  // literal / file marker bit
  localparam int unsigned F_SIZE   = 14;  // byte/word select
  localparam int unsigned F_DSEL   = 13;  // file form destination
  localparam int unsigned F_WIDE_LITERAL  = 4;   // wide literal lsb
  localparam int unsigned F_LREG   = 0;   // literal target register
  localparam int unsigned F_BASE   = 15;  // base register lsb
  localparam int unsigned F_QMODE  = 11;  // destination mode lsb
  localparam int unsigned F_DREG   = 7;   // destination register lsb
  localparam int unsigned F_SMARK  = 5;   // short literal marker lsb
  localparam int unsigned F_PMODE  = 4;   // source mode lsb
  localparam int unsigned F_SREG   = 0;   // source register lsb
  localparam int unsigned F_SHORT_LITERAL   = 0;   // short literal lsb
  localparam int unsigned F_FADR   = 0;   // file address lsb
  localparam int unsigned MEM_LO   = 1;   // lowest word-index address bit
  localparam int unsigned BSEL     = 0;   // byte lane address bit

  // -----------------------------------------------------------------
  // addressing modes (3-bit mode fields)
  // -----------------------------------------------------------------
  localparam logic [2:0] AM_DIRECT = 3'h0;  // register direct
  localparam logic [2:0] AM_IND    = 3'h1;  // [reg]
  localparam logic [2:0] AM_POSTDC = 3'h2;  // [reg--]
  localparam logic [2:0] AM_POSTIN = 3'h3;  // [reg++]
  localparam logic [2:0] AM_PREDC  = 3'h4;  // [--reg]
  localparam logic [2:0] AM_PREIN  = 3'h5;  // [++reg]
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // -----------------------------------------------------------------
  // status register bit positions and reset values
  // -----------------------------------------------------------------
  localparam int unsigned SR_C  = 0;
  localparam int unsigned SR_Z  = 1;
  localparam int unsigned SR_OV = 2;
  localparam int unsigned SR_N  = 3;
  localparam int unsigned SR_DC = 8;
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] W_RESET  = 16'h0000;
  localparam logic [RIDX_W-1:0] DEF_DEFAULT_WORK_REG = 4'h0;  // default working reg

  // -----------------------------------------------------------------
  // register port map (word indexes on bus_addr)
  // -----------------------------------------------------------------
  localparam logic [BUS_AW-1:0] RA_WLAST  = 14'h000f;  // W0..W15 at 0..15
  localparam logic [BUS_AW-1:0] RA_STATUS = 14'h0010;  // status flags
  localparam logic [BUS_AW-1:0] RA_COUNT  = 14'h0011;  // executed count
  localparam int unsigned       RA_MEMBIT = 13;        // set: data memory

endpackage : acl_pkg

/* File: hdl/acl_alu.sv */
/*
  combinational adder / AND stage with flag generation.
  assumes: operands arrive already selected; byte mode uses the low byte.
*/
`timescale 1ns/1ps
module acl_alu (
  // operation select
  input  wire logic                      op_and,
  input  wire logic                      byte_op,
  // operands
  input  wire logic [acl_pkg::XLEN-1:0]  opa,
  input  wire logic [acl_pkg::XLEN-1:0]  opb,
  input  wire logic                      cin,
  // result and flags
  output logic      [acl_pkg::XLEN-1:0]  res,
  output logic                           c_out,
  output logic                           dc_out,
  output logic                           ov_out,
  output logic                           n_out,
  output logic                           nz_out
);
  import acl_pkg::*;

  logic [16:0] sum_w;   // word sum with carry out
  logic [8:0]  sum_b;   // byte sum with carry out
  logic [4:0]  sum_n;   // nibble sum for the half carry
  logic        a_msb;   // sign of operand a
  logic        b_msb;   // sign of operand b

  // -----------------------------------------------------------------
  // arithmetic and flags
  // -----------------------------------------------------------------
  always_comb begin
    sum_w  = 17'(opa) + 17'(opb) + 17'(cin);
    sum_b  = 9'(opa[7:0]) + 9'(opb[7:0]) + 9'(cin);
    sum_n  = 5'(opa[3:0]) + 5'(opb[3:0]) + 5'(cin);
    a_msb  = byte_op ? opa[7] : opa[15];
    b_msb  = byte_op ? opb[7] : opb[15];
    dc_out = sum_n[4];
    if (op_and) begin
      res   = opa & opb;
      c_out = 1'b0;
    end else if (byte_op) begin
      res   = {8'h00, sum_b[7:0]};
      c_out = sum_b[8];
    end else begin
      res   = sum_w[15:0];
      c_out = sum_w[16];
    end
    n_out  = byte_op ? res[7] : res[15];
    // overflow: like-signed operands giving an opposite-signed sum
    ov_out = (a_msb == b_msb) && (n_out != a_msb);
    nz_out = byte_op ? (res[7:0] != 8'h00) : (res != 16'h0000);
  end

endmodule : acl_alu

/* File: hdl/acl_unit.sv */
/*
  execution unit for add-with-carry (literal, short literal, register
  forms) and the file register AND form, with sixteen working
  registers, status flags and an internal byte-addressed data memory.
  assumes: one instruction word per instr_valid pulse, on sys_clk;
  software reaches registers and memory over a plain strobe port.
*/
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module acl_unit (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // instruction issue
  input  wire logic                        instr_valid,
  input  wire logic [acl_pkg::IW-1:0]      instr_word,
  output logic                             instr_done,
  output logic                             instr_fault,
  output logic [acl_pkg::XLEN-1:0]         status_flags,
  // register port
  input  wire logic [acl_pkg::BUS_AW-1:0]  bus_addr,
  input  wire logic [acl_pkg::XLEN-1:0]    bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic [acl_pkg::XLEN-1:0]         bus_rdata
);
  import acl_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------

  // effective address {ea, updated pointer}; illegal modes take the
  // default branch, and the decoder faults them so no update is kept
  function automatic logic [31:0] ea_calc(input logic [2:0]  mode,
                                          input logic [15:0] ptr,
                                          input logic        byte_op);
    logic [15:0] step;
    logic [15:0] ea;
    logic [15:0] upd;
    step = byte_op ? STEP_BYTE : STEP_WORD;
    ea   = ptr;
    upd  = ptr;
    unique case (mode)
      AM_POSTDC: upd = ptr - step;
      AM_POSTIN: upd = ptr + step;
      AM_PREDC: begin
        upd = ptr - step;
        ea  = upd;
      end
      AM_PREIN: begin
        upd = ptr + step;
        ea  = upd;
      end
      default: begin
        ea  = ptr;
        upd = ptr;
      end
    endcase
    return {ea, upd};
  endfunction : ea_calc

  // true for the six defined addressing modes
  function automatic logic mode_ok(input logic [2:0] mode);
    return mode <= AM_PREIN;
  endfunction : mode_ok

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [XLEN-1:0] w_reg  [NREG];          // working registers
  logic [XLEN-1:0] w_next [NREG];
  logic [XLEN-1:0] mem    [2**MEM_AW];     // data memory, 16-bit words
  logic [XLEN-1:0] sr_reg;                 // status flags
  logic [XLEN-1:0] sr_next;
  logic [XLEN-1:0] cnt_reg;                // executed instructions
  logic [XLEN-1:0] cnt_next;
  logic            done_reg;
  logic            done_next;
  logic            fault_reg;
  logic            fault_next;
  logic [XLEN-1:0] rdata_reg;
  logic [XLEN-1:0] rdata_next;

  // memory write port, computed combinationally
  logic              mem_we;
  logic [MEM_AW-1:0] mem_widx;
  logic [XLEN-1:0]   mem_wdata;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  logic              is_lit;     // literal form
  logic              is_reg;     // short literal or register form
  logic              is_short;   // short literal form
  logic              is_fand;    // file register AND
  logic              byte_op;    // byte operation
  logic [2:0]        qmode;      // destination mode
  logic [2:0]        pmode;      // source mode
  logic [RIDX_W-1:0] base_idx;
  logic [RIDX_W-1:0] dst_idx;
  logic [RIDX_W-1:0] src_idx;
  logic [RIDX_W-1:0] lit_idx;

  always_comb begin
    is_lit   = (instr_word[F_OPC8 +: 8] == OPC_LIT_ADD_WITH_CARRY)
               && (instr_word[F_MARK] == LIT_MARK);
    is_reg   = (instr_word[F_OPC5 +: 5] == OPC_REG_ADD_WITH_CARRY);
    is_short = is_reg && (instr_word[F_SMARK +: 2] == SHORT_MARK);
    is_fand  = (instr_word[F_OPC8 +: 8] == OPC_FILE_AND)
               && (instr_word[F_MARK] == FAND_MARK);
    byte_op  = instr_word[F_SIZE];
    qmode    = instr_word[F_QMODE +: 3];
    pmode    = instr_word[F_PMODE +: 3];
    base_idx = instr_word[F_BASE +: RIDX_W];
    dst_idx  = instr_word[F_DREG +: RIDX_W];
    src_idx  = instr_word[F_SREG +: RIDX_W];
    lit_idx  = instr_word[F_LREG +: RIDX_W];
  end

  // -----------------------------------------------------------------
  // operand fetch
  // -----------------------------------------------------------------
  logic [31:0]       src_ea;     // {address, pointer update}
  logic [31:0]       dst_ea;
  logic [15:0]       src_word;   // memory word under source address
  logic [15:0]       src_val;
  logic [15:0]       file_word;
  logic [15:0]       file_val;
  logic [15:0]       opa;
  logic [15:0]       opb;
  logic              op_and;
  logic              legal;
  logic [FADR_W-1:0] fadr;

  always_comb begin
    src_ea    = ea_calc(pmode, w_reg[src_idx], byte_op);
    dst_ea    = ea_calc(qmode, w_reg[dst_idx], byte_op);
    fadr      = instr_word[F_FADR +: FADR_W];
    src_word  = mem[src_ea[16 + MEM_LO +: MEM_AW]];
    file_word = mem[fadr[MEM_LO +: MEM_AW]];
    // byte reads take the lane picked by the lowest address bit
    if (pmode == AM_DIRECT) begin
      src_val = w_reg[src_idx];
    end else if (byte_op) begin
      src_val = src_ea[16 + BSEL] ? {8'h00, src_word[15:8]}
                                  : {8'h00, src_word[7:0]};
    end else begin
      src_val = src_word;
    end
    if (byte_op) begin
      file_val = fadr[BSEL] ? {8'h00, file_word[15:8]}
                            : {8'h00, file_word[7:0]};
    end else begin
      file_val = file_word;
    end
    op_and = is_fand;
    legal  = 1'b1;
    opa    = w_reg[base_idx];
    opb    = 16'h0000;
    if (is_lit) begin
      opa = w_reg[lit_idx];
      // byte mode takes the low eight literal bits only
      opb = 16'(instr_word[F_WIDE_LITERAL +: WIDE_LITERAL_W]);
    end else if (is_short) begin
      opb   = 16'(instr_word[F_SHORT_LITERAL +: SHORT_LITERAL_W]);
      legal = mode_ok(qmode);
    end else if (is_reg) begin
      opb   = src_val;
      legal = mode_ok(qmode) && mode_ok(pmode);
    end else if (is_fand) begin
      opa = file_val;
      opb = w_reg[DEF_DEFAULT_WORK_REG];
    end else begin
      legal = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // arithmetic stage
  // -----------------------------------------------------------------
  logic [15:0] res;
  logic        f_c;
  logic        f_dc;
  logic        f_ov;
  logic        f_n;
  logic        f_nz;

  acl_alu u_alu (
    .op_and  (op_and),
    .byte_op (byte_op),
    .opa     (opa),
    .opb     (opb),
    .cin     (sr_reg[SR_C]),
    .res     (res),
    .c_out   (f_c),
    .dc_out  (f_dc),
    .ov_out  (f_ov),
    .n_out   (f_n),
    .nz_out  (f_nz)
  );

  // -----------------------------------------------------------------
  // write-back, flags and register port (next values)
  // -----------------------------------------------------------------
  logic              exec;       // legal instruction this cycle
  logic [15:0]       wr_ea;      // memory destination address
  logic              to_mem;     // result goes to memory
  logic              to_reg;     // result goes to a register
  logic [RIDX_W-1:0] res_idx;    // register receiving the result
  logic [15:0]       mem_old;

  always_comb begin
    exec       = instr_valid && legal;
    w_next     = w_reg;
    sr_next    = sr_reg;
    cnt_next   = cnt_reg;
    done_next  = exec;
    fault_next = instr_valid && !legal;
    rdata_next = 16'h0000;
    to_mem     = 1'b0;
    to_reg     = 1'b0;
    res_idx    = dst_idx;
    wr_ea      = dst_ea[31:16];
    if (is_lit) begin
      to_reg  = 1'b1;
      res_idx = lit_idx;
    end else if (is_reg) begin
      to_reg = (qmode == AM_DIRECT);
      to_mem = (qmode != AM_DIRECT);
    end else if (is_fand) begin
      to_reg  = !instr_word[F_DSEL];
      to_mem  = instr_word[F_DSEL];
      res_idx = DEF_DEFAULT_WORK_REG;
      wr_ea   = 16'(fadr);
    end
    mem_old   = mem[wr_ea[MEM_LO +: MEM_AW]];
    mem_widx  = wr_ea[MEM_LO +: MEM_AW];
    mem_we    = exec && to_mem;
    // byte stores touch only the addressed lane
    if (!byte_op) begin
      mem_wdata = res;
    end else if (wr_ea[BSEL]) begin
      mem_wdata = {res[7:0], mem_old[7:0]};
    end else begin
      mem_wdata = {mem_old[15:8], res[7:0]};
    end
    if (exec) begin
      cnt_next = cnt_reg + 16'h0001;
      // pointer updates: source first, destination second, result last
      if (is_reg && !is_short && pmode != AM_DIRECT) begin
        w_next[src_idx] = src_ea[15:0];
      end
      if (is_reg && qmode != AM_DIRECT) begin
        w_next[dst_idx] = dst_ea[15:0];
      end
      if (to_reg) begin
        w_next[res_idx] = byte_op ? {w_reg[res_idx][15:8], res[7:0]}
                                  : res;
      end
      sr_next[SR_N] = f_n;
      if (is_fand) begin
        sr_next[SR_Z] = !f_nz;
      end else begin
        sr_next[SR_C]  = f_c;
        sr_next[SR_DC] = f_dc;
        sr_next[SR_OV] = f_ov;
        // sticky zero: a non-zero result clears it, only the AND form or a status write sets it
        sr_next[SR_Z]  = sr_reg[SR_Z] && !f_nz;
      end
    end else if (bus_wr && !instr_valid) begin
      // software writes yield to an instruction issued in the same cycle
      if (bus_addr[RA_MEMBIT]) begin
        mem_we    = 1'b1;
        mem_widx  = bus_addr[MEM_AW-1:0];
        mem_wdata = bus_wdata;
      end else if (bus_addr <= RA_WLAST) begin
        w_next[bus_addr[RIDX_W-1:0]] = bus_wdata;
      end else if (bus_addr == RA_STATUS) begin
        sr_next = bus_wdata;
      end
    end
    // reads show state before any same-cycle write
    if (bus_rd) begin
      if (bus_addr[RA_MEMBIT]) begin
        rdata_next = mem[bus_addr[MEM_AW-1:0]];
      end else if (bus_addr <= RA_WLAST) begin
        rdata_next = w_reg[bus_addr[RIDX_W-1:0]];
      end else if (bus_addr == RA_STATUS) begin
        rdata_next = sr_reg;
      end else if (bus_addr == RA_COUNT) begin
        rdata_next = cnt_reg;
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        w_reg[i] <= W_RESET;
      end
      sr_reg    <= SR_RESET;
      cnt_reg   <= 16'h0000;
      done_reg  <= 1'b0;
      fault_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      w_reg     <= w_next;
      sr_reg    <= sr_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
      fault_reg <= fault_next;
      rdata_reg <= rdata_next;
    end
  end

  // memory array holds no reset; software initialises what it uses
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wdata;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign instr_done   = done_reg;
  assign instr_fault  = fault_reg;
  assign status_flags = sr_reg;
  assign bus_rdata    = rdata_reg;

endmodule : acl_unit

/* File: verification/acl_unit_chk.sv */
/* port assertions for the add-with-carry and logic unit.
   assumes: bound to acl_unit, one clock, synchronous active-high reset. */
`timescale 1ns/1ps
module acl_unit_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // instruction issue
  input wire logic        instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic        instr_done,
  input wire logic        instr_fault,
  input wire logic [15:0] status_flags,
  // register port
  input wire logic [13:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata
);
  // add-with-carry short / register form prefix seen this cycle
  wire logic add_sel   = instr_valid && instr_word[23:19] == 5'h09;
  // file register AND prefix seen this cycle
  wire logic fand_sel  = instr_valid && instr_word[23:16] == 8'hb6;
  // software write that sets the zero bit of the status word
  wire logic z_written = bus_wr && !instr_valid && bus_addr == 14'h0010 && bus_wdata[1];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_answer; instr_valid |=> instr_done != instr_fault; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_quiet; !instr_valid |=> !instr_done && !instr_fault; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without issue");
  property p_lit; instr_valid && instr_word[23:15] == 9'h161 |=> instr_done; endproperty
  a_lit: assert property (p_lit) else $error("literal form not run");
  property p_file; instr_valid && instr_word[23:15] == 9'h16c |=> instr_done; endproperty
  a_file: assert property (p_file) else $error("file form not run");
  property p_short;
    add_sel && instr_word[13:11] < 3'h6 && instr_word[6:5] == 2'h3 |=> instr_done;
  endproperty
  a_short: assert property (p_short) else $error("short form not run");
  property p_badmode;
    add_sel && instr_word[13:11] > 3'h5 |=> instr_fault ##0 $stable(status_flags);
  endproperty
  a_badmode: assert property (p_badmode) else $error("bad mode accepted");
  // zero may only rise through the AND form or a status write
  property p_sticky; $rose(status_flags[1]) |-> $past(fand_sel) || $past(z_written); endproperty
  a_sticky: assert property (p_sticky) else $error("zero flag set");
  property p_andflags;
    fand_sel |=> $stable({status_flags[8], status_flags[2], status_flags[0]});
  endproperty
  a_andflags: assert property (p_andflags) else $error("AND touched carry flags");
endmodule : acl_unit_chk
bind acl_unit acl_unit_chk u_chk (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_done(instr_done), .instr_fault(instr_fault), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .instr_word(instr_word), .status_flags(status_flags), .bus_rdata(bus_rdata),
  .bus_wdata(bus_wdata), .bus_addr(bus_addr));

/* File: verification/acl_unit_tb.sv */
/* self-checking bench for acl_unit: random and corner instructions.
   assumes: acl_pkg and the design compiled first; checker bound apart. */
`timescale 1ns/1ps
module acl_unit_tb;
  import acl_pkg::*;
  logic        sys_clk, rst, instr_valid, bus_wr, bus_rd, instr_done, instr_fault, c, z, bt;
  logic [23:0] instr_word;
  logic [15:0] status_flags, bus_wdata, bus_rdata, v1, v2, v3, p, ea;
  logic [13:0] bus_addr;
  logic [31:0] e;
  logic [9:0]  lit;
  logic [3:0]  r1, r2, r3;
  int unsigned sd;
  int          err_count = 0, checks = 0, cyc = 0;
  acl_unit DUT (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_done(instr_done), .instr_fault(instr_fault),
    .status_flags(status_flags), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin err_count++; $display("BAD %s exp %h seen %h", nm, exp, seen); end
  endtask : chk
  // strobes drop on the next edge and a spare cycle follows, so no double drive
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1; @(posedge sys_clk);
    bus_wr <= 1'b0; @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [15:0] x, input string nm);
    bus_addr <= a; bus_rd <= 1'b1; @(posedge sys_clk);
    bus_rd <= 1'b0; @(negedge sys_clk); chk(nm, bus_rdata, x); @(posedge sys_clk);
  endtask : rd
  task automatic ex(input logic [23:0] w, input logic f);
    instr_word <= w; instr_valid <= 1'b1; @(posedge sys_clk);
    instr_valid <= 1'b0; @(negedge sys_clk);
    chk("answer", {14'h0, instr_fault, instr_done}, {14'h0, f, !f});
    @(posedge sys_clk);
  endtask : ex
  // expected {status, result}; byte mode keeps the old destination's upper byte
  function automatic logic [31:0] add_with_carry(input logic [15:0] a, b, d, input logic c, bt, z);
    logic [16:0] s; logic [4:0] h; logic [15:0] q; logic cy, ov, ng, zf;
    h = a[3:0] + b[3:0] + c;
    if (bt) begin
      s = a[7:0] + b[7:0] + c; q = {d[15:8], s[7:0]}; cy = s[8]; ng = q[7];
      ov = (a[7] == b[7]) && (s[7] != a[7]); zf = z && (q[7:0] == 8'h0);
    end else begin
      s = a + b + c; q = s[15:0]; cy = s[16]; ng = q[15];
      ov = (a[15] == b[15]) && (s[15] != a[15]); zf = z && (q == 16'h0);
    end
    add_with_carry = {7'h0, h[4], 4'h0, ng, ov, zf, cy, q};
  endfunction : add_with_carry
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin err_count++; tally_and_finish(); end
  end
  initial begin
    rst = 1'b1; instr_valid = 1'b0; instr_word = 24'h0; bus_wr = 1'b0; bus_rd = 1'b0;
    bus_addr = 14'h0; bus_wdata = 16'h0; sd = $urandom(32'h4c07_d98a);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0; @(posedge sys_clk);
    for (int i = 0; i < 18; i++) rd(14'(i), 16'h0, "reset");
    rd(14'h0012, 16'h0, "unmapped");
    // three forms in turn; first round sums to zero with carry out
    for (int i = 0; i < 36; i++) begin
      r1 = 4'($urandom); r2 = r1 + 4'h5; r3 = r1 + 4'hb; bt = 1'($urandom); c = 1'($urandom);
      z = 1'($urandom); v1 = 16'($urandom); v2 = 16'($urandom); v3 = 16'($urandom);
      lit = bt ? 10'($urandom % 256) : 10'($urandom);
      if (i < 3) begin v1 = 16'hffff; v3 = 16'h0; lit = 10'h0; c = 1'b1; z = 1'b1; end
      wr(14'(r1), v1); wr(14'(r2), v2); wr(14'(r3), v3); wr(14'h0010, {14'h0, z, c});
      case (i % 3)
        0: begin ex({8'hb0, 1'b1, bt, lit, r1}, 1'b0);
          e = add_with_carry(v1, {6'h0, lit}, v1, c, bt, z); r2 = r1; end
        1: begin ex({5'h09, r1, bt, 3'h0, r2, 2'h3, lit[4:0]}, 1'b0);
          e = add_with_carry(v1, {11'h0, lit[4:0]}, v2, c, bt, z); end
        default: begin ex({5'h09, r1, bt, 3'h0, r2, 3'h0, r3}, 1'b0);
          e = add_with_carry(v1, v3, v2, c, bt, z); end
      endcase
      rd({10'h0, r2}, e[15:0], "result");
      rd(14'h0010, e[31:16], "flags");
      chk("flags_port", status_flags, e[31:16]);
    end
    // destination modes 1 to 5, mode 6 refused
    for (int m = 1; m < 7; m++) begin
      wr(14'h0005, 16'h0100); wr(14'h0006, 16'h0); wr(14'h0010, 16'h0);
      p = (m == 2 || m == 4) ? 16'h00fe : (m == 3 || m == 5) ? 16'h0102 : 16'h0100;
      ea = (m < 4) ? 16'h0100 : p;
      ex({5'h09, 4'h6, 1'b0, 3'(m), 4'h5, 2'h3, 5'(m)}, m == 6);
      if (m < 6) rd(14'h2000 | 14'(ea >> 1), 16'(m), "ind");
      rd(14'h0005, p, "ptr");
    end
    wr(14'h0003, 16'h6006); wr(14'h0002, 16'h0800); wr(14'h0004, 16'h1000);
    wr(14'h2400, 16'h2500); wr(14'h0010, 16'h0001);
    ex({5'h09, 4'h3, 1'b0, 3'h4, 4'h4, 3'h3, 4'h2}, 1'b0);
    rd(14'h27ff, 16'h8507, "sum");
    rd(14'h0002, 16'h0802, "src_ptr");
    rd(14'h0004, 16'h0ffe, "dst_ptr");
    rd(14'h0010, 16'h000c, "ovf");
    wr(14'h0000, 16'hcc80); wr(14'h2100, 16'h12c0); wr(14'h0010, 16'h0003);
    ex({8'hb6, 3'b000, 13'h0200}, 1'b0);
    rd(14'h0000, 16'h0080, "and_w0");
    rd(14'h0010, 16'h0001, "and_f1");
    ex({8'hb6, 3'b011, 13'h0200}, 1'b0);
    rd(14'h2100, 16'h1280, "and_file");
    rd(14'h0010, 16'h0009, "and_f2");
    // 36 random, 5 legal modes, 1 register form, 2 AND; the refused one not counted
    rd(14'h0011, 16'h002c, "count");
    tally_and_finish();
  end
endmodule : acl_unit_tb
